/* File: rtl/pcg_consts.svh */
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH

// Register selects on the special function register port
`define PCG_REG_CTRL 2'h0
`define PCG_REG_TAPS 2'h1
`define PCG_REG_DATA 2'h2
`define PCG_REG_SHIFT 2'h3

// Control/status field positions
`define PCG_IDLE_STOP_BIT 13
`define PCG_FILL_LSB 8
`define PCG_FILL_MSB 12
`define PCG_FULL_BIT 7
`define PCG_EMPTY_BIT 6
`define PCG_GO_BIT 4
`define PCG_POLY_LENGTH_LSB 0
`define PCG_POLY_LENGTH_MSB 3

// Reset values
`define PCG_POLY_LENGTH_RST 4'h0
`define PCG_TAPS_RST 15'h0000
`define PCG_CRC_RST 16'h0000

// Storage geometry and mode threshold
`define PCG_FIFO_BYTES 5'h10
`define PCG_BYTE_MODE_MAX_POLY_LENGTH 4'h7
`define PCG_BYTE_LAST_BIT 4'h7
`define PCG_WORD_LAST_BIT 4'hF

`endif

/* File: rtl/pcg_pkg.sv */
package pcg_pkg;

  // Shifter control states, Gray coded along idle -> run -> halted
  typedef enum logic [1:0] {
    PCG_ST_IDLE = 2'b00,
    PCG_ST_RUN = 2'b01,
    PCG_ST_HALT = 2'b11
  } pcg_state_t;

  typedef logic [7:0] pcg_byte_t;
  typedef logic [15:0] pcg_word_t;

endpackage : pcg_pkg

/* File: rtl/pcg_feed_if.sv */
`timescale 1ns/1ps
// Head-of-FIFO entry offered to the serial shifter
interface pcg_feed_if;
  logic valid;
  logic wide;
  pcg_pkg::pcg_word_t data;
  logic pop;

  modport fifo (output valid, output wide, output data, input pop);
  modport shifter (input valid, input wide, input data, output pop);
endinterface : pcg_feed_if

/* File: rtl/pcg_fifo.sv */
`timescale 1ns/1ps
`include "pcg_consts.svh"

module pcg_fifo #(
  parameter int DEPTH_BYTES = 16
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [1:0] wr_be,
  input wire logic [15:0] wr_data,
  input wire logic byte_mode,
  pcg_feed_if.fifo feed,
  output logic [4:0] fill_count,
  output logic full,
  output logic empty
);
  pcg_pkg::pcg_byte_t mem [DEPTH_BYTES];
  logic [3:0] wr_ptr;
  logic [3:0] rd_ptr;
  logic [4:0] bytes;

  wire [4:0] n_in = {4'h0, wr_be[0]} + {4'h0, wr_be[1]};
  wire [4:0] n_out = byte_mode ? 5'h01 : 5'h02;
  // Overflowing writes are dropped rather than wrapping onto live data
  wire accept = wr_en && (n_in != 5'h00) && ((bytes + n_in) <= `PCG_FIFO_BYTES);
  wire take = feed.pop && feed.valid;
  wire [4:0] next_bytes = bytes + (accept ? n_in : 5'h00) - (take ? n_out : 5'h00);
  wire [7:0] lone_byte = wr_be[0] ? wr_data[7:0] : wr_data[15:8];
  wire [3:0] rd_ptr_hi = rd_ptr + 4'h1;

  // Entry count: bytes in byte mode, whole words otherwise (odd byte waits)
  assign fill_count = byte_mode ? bytes : {1'b0, bytes[4:1]};
  assign full = (bytes == `PCG_FIFO_BYTES);
  assign empty = (fill_count == 5'h00);
  assign feed.valid = !empty;
  assign feed.wide = !byte_mode;
  // Entries left aligned so the shifter always starts at bit 15
  assign feed.data = byte_mode ? {mem[rd_ptr], 8'h00} : {mem[rd_ptr_hi], mem[rd_ptr]};

  // Pointer and count update; storage itself needs no reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      bytes <= 5'h00;
    end else begin
      bytes <= next_bytes;
      if (accept) begin
        wr_ptr <= wr_ptr + n_in[3:0];
      end
      if (take) begin
        rd_ptr <= rd_ptr + n_out[3:0];
      end
    end
  end

  // Byte lanes land little endian, low lane first
  always_ff @(posedge core_clk) begin
    if (accept && (n_in == 5'h02)) begin
      mem[wr_ptr] <= wr_data[7:0];
      mem[wr_ptr + 4'h1] <= wr_data[15:8];
    end else if (accept) begin
      mem[wr_ptr] <= lone_byte;
    end
  end
endmodule : pcg_fifo

/* File: rtl/pcg_engine.sv */
`timescale 1ns/1ps
`include "pcg_consts.svh"

module pcg_engine #(
  parameter int WIDTH = 16
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic shift,
  input wire logic in_bit,
  input wire logic [WIDTH-1:1] taps,
  input wire logic [3:0] poly_length,
  output logic [WIDTH-1:0] crc
);
  logic [WIDTH-1:0] next_crc;
  logic [WIDTH-1:0] len_mask;
  // Feedback taken from the register bit the length selects
  wire feedback = in_bit ^ crc[poly_length];

  // Bit 0 always takes feedback: the constant term
  assign len_mask[0] = 1'b1;
  assign next_crc[0] = feedback;
  for (genvar n = 1; n < WIDTH; n++) begin : g_stage
    assign len_mask[n] = (n <= int'(poly_length));
    assign next_crc[n] = (crc[n-1] ^ (taps[n] & feedback)) & len_mask[n];
  end

  // Direct write wins over a shift in the same cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      crc <= `PCG_CRC_RST;
    end else if (load) begin
      crc <= load_value & len_mask;
    end else if (shift) begin
      crc <= next_crc;
    end
  end
endmodule : pcg_engine

/* File: rtl/pcg_top.sv */
`timescale 1ns/1ps
`include "pcg_consts.svh"

// How it works
// - Software programs polynomial taps and length.
// - FIFO is 8x16 or 16x8.
// - Register port, FIFO, interrupt, engine feed.
// - Bit-serial XOR shifter divides the stream.
// - Four registers mapped on the register port.
// - Tap register picks feedback XOR terms.
// - Data register feeds FIFO; shift register holds result.
// - Idle-stop halts shifting during system idle.
// - Read-only five-bit FIFO fill count.
// - Fill limit 8 words or 16 bytes.
// - Full flag reads one when FIFO full.
// - Empty flag reads one, resets to one.
// - Shift-enable one starts the serial shifter.
// - Clearing shift-enable stops only once empty.
// - Polynomial length is field plus one.
// - Bits 15, 14, 5 read zero.
// - Tap bits 15..1 add terms; x0 always.
// - Byte mode: byte adds one, word two.
// - Shift MSb first, only while running, nonempty.
// - Entry finished: count drops, full clears.

module pcg_top (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [1:0] sfr_sel,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [1:0] sfr_be,
  input wire logic [15:0] sfr_wdata,
  output logic [15:0] sfr_rdata,
  input wire logic sys_idle,
  output logic irq_pulse
);
  // Control fields
  logic idle_stop;
  logic shift_enable;
  logic [3:0] poly_length;
  logic [15:1] polynomial_taps;

  // Shifter state and delayed empty flag
  pcg_pkg::pcg_state_t state;
  pcg_pkg::pcg_state_t next_state;
  logic [3:0] bit_idx;
  logic empty_d;

  // FIFO status and checksum value
  logic [4:0] fifo_fill_count;
  logic fifo_full_flag;
  logic fifo_empty_flag;
  logic [15:0] crc_value;

  pcg_feed_if feed ();

  // Register select decode
  wire sel_ctrl = (sfr_sel == `PCG_REG_CTRL);
  wire sel_taps = (sfr_sel == `PCG_REG_TAPS);
  wire sel_data = (sfr_sel == `PCG_REG_DATA);
  wire sel_shift = (sfr_sel == `PCG_REG_SHIFT);

  // Byte lane strobes per register
  wire wr_ctrl_lo = sfr_wr && sel_ctrl && sfr_be[0];
  wire wr_ctrl_hi = sfr_wr && sel_ctrl && sfr_be[1];
  wire wr_taps_lo = sfr_wr && sel_taps && sfr_be[0];
  wire wr_taps_hi = sfr_wr && sel_taps && sfr_be[1];
  wire wr_data = sfr_wr && sel_data;
  // A partial write to the shift register only makes sense as a whole word
  wire wr_shift = sfr_wr && sel_shift && (sfr_be == 2'b11);

  // Mode selection from the length field
  wire byte_mode = (poly_length <= `PCG_BYTE_MODE_MAX_POLY_LENGTH);
  wire halt = idle_stop && sys_idle;

  // Shifting happens only in run with an entry waiting
  wire shift_step = (state == pcg_pkg::PCG_ST_RUN) && feed.valid && !wr_shift;
  wire [3:0] last_idx = feed.wide ? `PCG_WORD_LAST_BIT : `PCG_BYTE_LAST_BIT;
  wire entry_done = shift_step && (bit_idx == last_idx);
  wire in_bit = feed.data[4'hF - bit_idx];

  assign feed.pop = entry_done;

  // Read views of each register
  wire [15:0] ctrl_view = {
    2'b00,
    idle_stop,
    fifo_fill_count,
    fifo_full_flag,
    fifo_empty_flag,
    1'b0,
    shift_enable,
    poly_length
  };
  wire [15:0] taps_view = {polynomial_taps, 1'b0};
  // The data register is write only and reads as zero
  wire [15:0] read_mux = sel_ctrl ? ctrl_view :
                         sel_taps ? taps_view :
                         sel_shift ? crc_value : 16'h0000;

  // Control register write; unimplemented bits are simply not stored
  always_ff @(posedge core_clk) begin
    if (srst) begin
      idle_stop <= 1'b0;
      shift_enable <= 1'b0;
      poly_length <= `PCG_POLY_LENGTH_RST;
    end else begin
      if (wr_ctrl_hi) begin
        idle_stop <= sfr_wdata[`PCG_IDLE_STOP_BIT];
      end
      if (wr_ctrl_lo) begin
        shift_enable <= sfr_wdata[`PCG_GO_BIT];
        poly_length <= sfr_wdata[`PCG_POLY_LENGTH_MSB:`PCG_POLY_LENGTH_LSB];
      end
    end
  end

  // Polynomial tap register, byte lanes written independently
  always_ff @(posedge core_clk) begin
    if (srst) begin
      polynomial_taps <= `PCG_TAPS_RST;
    end else begin
      if (wr_taps_lo) begin
        polynomial_taps[7:1] <= sfr_wdata[7:1];
      end
      if (wr_taps_hi) begin
        polynomial_taps[15:8] <= sfr_wdata[15:8];
      end
    end
  end

  // Next shifter state
  always_comb begin
    next_state = state;
    unique case (state)
      pcg_pkg::PCG_ST_IDLE: begin
        if (shift_enable && feed.valid && !halt) begin
          next_state = pcg_pkg::PCG_ST_RUN;
        end
      end
      pcg_pkg::PCG_ST_RUN: begin
        if (halt) begin
          next_state = pcg_pkg::PCG_ST_HALT;
        end else if (!shift_enable && fifo_empty_flag) begin
          next_state = pcg_pkg::PCG_ST_IDLE;
        end
      end
      pcg_pkg::PCG_ST_HALT: begin
        if (!halt) begin
          next_state = pcg_pkg::PCG_ST_RUN;
        end
      end
      default: begin
        next_state = pcg_pkg::PCG_ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= pcg_pkg::PCG_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Bit position inside the head entry, held across halts
  always_ff @(posedge core_clk) begin
    if (srst) begin
      bit_idx <= 4'h0;
    end else if (entry_done) begin
      bit_idx <= 4'h0;
    end else if (shift_step) begin
      bit_idx <= bit_idx + 4'h1;
    end
  end

  // Interrupt on the FIFO draining while the shifter is active
  always_ff @(posedge core_clk) begin
    if (srst) begin
      empty_d <= 1'b1;
      irq_pulse <= 1'b0;
    end else begin
      empty_d <= fifo_empty_flag;
      irq_pulse <= fifo_empty_flag && !empty_d && (state != pcg_pkg::PCG_ST_IDLE);
    end
  end

  // Registered read data, zero when not reading
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sfr_rdata <= 16'h0000;
    end else begin
      sfr_rdata <= sfr_rd ? read_mux : 16'h0000;
    end
  end

  // Input FIFO
  pcg_fifo #(
    .DEPTH_BYTES(16)
  ) u_fifo (
    .core_clk(core_clk),
    .srst(srst),
    .wr_en(wr_data),
    .wr_be(sfr_be),
    .wr_data(sfr_wdata),
    .byte_mode(byte_mode),
    .feed(feed),
    .fill_count(fifo_fill_count),
    .full(fifo_full_flag),
    .empty(fifo_empty_flag)
  );

  // Checksum shifter
  pcg_engine #(
    .WIDTH(16)
  ) u_engine (
    .core_clk(core_clk),
    .srst(srst),
    .load(wr_shift),
    .load_value(sfr_wdata),
    .shift(shift_step),
    .in_bit(in_bit),
    .taps(polynomial_taps),
    .poly_length(poly_length),
    .crc(crc_value)
  );
endmodule : pcg_top

/* File: test/pcg_top_assertions.sv */
`timescale 1ns/1ps
// Register-view checks judged on the answer one cycle after each read, plus idle read data and interrupt pulse width
module pcg_top_assertions (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [1:0] sfr_sel,
  input wire logic sfr_rd,
  input wire logic [15:0] sfr_rdata,
  input wire logic irq_pulse
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  // Read strobes for the control, tap and data registers
  sequence ctrl_read;
    sfr_rd && sfr_sel == 2'h0;
  endsequence
  sequence taps_read;
    sfr_rd && sfr_sel == 2'h1;
  endsequence
  sequence data_read;
    sfr_rd && sfr_sel == 2'h2;
  endsequence

  // Limit depends on the length field seen in the same answer
  wire logic [4:0] fill_view = sfr_rdata[12:8];
  wire logic [4:0] fill_max = (sfr_rdata[3:0] > 4'h7) ? 5'h08 : 5'h10;

  AST_RDATA_IDLE: assert property (!sfr_rd |=> sfr_rdata == 16'h0000)
    else $error("read data not zero without a read");
  AST_CTRL_UNIMP: assert property (ctrl_read |=> sfr_rdata[15:14] == 2'h0 && !sfr_rdata[5])
    else $error("reserved control bits not zero");
  AST_EMPTY_FLAG: assert property (ctrl_read |=> sfr_rdata[6] == (fill_view == 5'h00))
    else $error("empty flag disagrees with fill count");
  AST_FILL_LIMIT: assert property (ctrl_read |=> fill_view <= fill_max)
    else $error("fill count above limit");
  AST_FULL_FLAG: assert property (ctrl_read |=> sfr_rdata[7] == (fill_view == fill_max))
    else $error("full flag disagrees with fill count");
  AST_DATA_READ: assert property (data_read |=> sfr_rdata == 16'h0000)
    else $error("data register read not zero");
  AST_TAPS_BIT0: assert property (taps_read |=> !sfr_rdata[0])
    else $error("tap bit zero not zero");
  AST_IRQ_PULSE: assert property (irq_pulse |=> !irq_pulse)
    else $error("interrupt wider than one cycle");
endmodule : pcg_top_assertions

bind pcg_top pcg_top_assertions u_pcg_top_assertions (.core_clk(core_clk), .srst(srst), .sfr_sel(sfr_sel),
  .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .irq_pulse(irq_pulse));

/* File: test/test_pcg_top.sv */
`timescale 1ns/1ps
module test_pcg_top;
  logic core_clk;
  logic srst;
  logic [1:0] sfr_sel;
  logic sfr_wr;
  logic sfr_rd;
  logic [1:0] sfr_be;
  logic [15:0] sfr_wdata;
  logic [15:0] sfr_rdata;
  logic sys_idle;
  logic irq_pulse;
  int num_errors;
  int samples_checked;
  int irq_count;
  logic [15:0] exp_crc;

  pcg_top u_pcg_top (.core_clk(core_clk), .srst(srst), .sfr_sel(sfr_sel), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_be(sfr_be), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sys_idle(sys_idle), .irq_pulse(irq_pulse));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Interrupt pulses, checked once at the end
  always @(posedge core_clk) begin
    if (irq_pulse === 1'b1) irq_count++;
  end

  // Two cycles per access so strobes never change twice in one step
  task automatic wr(input logic [1:0] sel, input logic [1:0] be, input logic [15:0] data);
    @(posedge core_clk);
    #1;
    sfr_sel = sel;
    sfr_be = be;
    sfr_wdata = data;
    sfr_wr = 1'b1;
    @(posedge core_clk);
    #1;
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] sel, output logic [15:0] data);
    @(posedge core_clk);
    #1;
    sfr_sel = sel;
    sfr_rd = 1'b1;
    @(posedge core_clk);
    #1;
    sfr_rd = 1'b0;
    data = sfr_rdata;
  endtask : rd

  task automatic check(input logic [1:0] sel, input logic [15:0] exp);
    logic [15:0] d;
    rd(sel, d);
    samples_checked++;
    if (d !== exp) begin
      num_errors++;
      $display("ERROR at %0t: reg %0d read %h, expected %h", $time, sel, d, exp);
    end
  endtask : check

  // Polls the empty flag; bound covers 16 byte entries with margin
  task automatic wait_empty();
    logic [15:0] d;
    d = 16'h0000;
    for (int n = 0; n < 200 && d[6] !== 1'b1; n++) rd(2'h0, d);
    if (d[6] !== 1'b1) begin
      num_errors++;
      $display("ERROR at %0t: FIFO never drained", $time);
      conclude();
    end
  endtask : wait_empty

  // Reference division, MSb first, register width len+1, x0 always in
  function automatic logic [15:0] crc_feed(input logic [15:0] c, input logic [15:0] d, input int nbits,
      input logic [3:0] len, input logic [15:0] taps);
    logic fb;
    for (int i = nbits - 1; i >= 0; i--) begin
      fb = d[i] ^ c[len];
      c = c << 1;
      if (fb) c = c ^ {taps[15:1], 1'b1};
      c = c & ((16'h0002 << len) - 16'h0001);
    end
    return c;
  endfunction : crc_feed

  task automatic conclude();
    $display("checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  initial begin
    srst = 1'b1;
    sfr_sel = 2'h0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_be = 2'h0;
    sfr_wdata = 16'h0000;
    sys_idle = 1'b0;
    num_errors = 0;
    samples_checked = 0;
    irq_count = 0;
    repeat (6) @(posedge core_clk);
    #1;
    srst = 1'b0;
    // Reset view and readback of reserved bits
    check(2'h0, 16'h0040);
    check(2'h1, 16'h0000);
    check(2'h3, 16'h0000);
    check(2'h2, 16'h0000);
    wr(2'h1, 2'h3, 16'hFFFF);
    check(2'h1, 16'hFFFE);
    wr(2'h0, 2'h3, 16'hFFEF);
    check(2'h0, 16'h204F);
    // Word mode: one entry through x^16+x^12+x^5+1
    wr(2'h0, 2'h3, 16'h000F);
    wr(2'h1, 2'h3, 16'h1020);
    wr(2'h3, 2'h3, 16'h0000);
    wr(2'h2, 2'h3, 16'h1234);
    check(2'h0, 16'h010F);
    wr(2'h0, 2'h3, 16'h001F);
    wait_empty();
    check(2'h3, crc_feed(16'h0000, 16'h1234, 16, 4'hF, 16'h1020));
    // Byte mode: fill to full, hold in idle, drain with go cleared
    wr(2'h0, 2'h3, 16'h0007);
    wr(2'h1, 2'h3, 16'h0006);
    wr(2'h3, 2'h3, 16'h0000);
    wr(2'h2, 2'h3, 16'hA55A);
    wr(2'h2, 2'h1, 16'h003C);
    check(2'h0, 16'h0307);
    exp_crc = crc_feed(16'h0000, 16'h5AA5, 16, 4'h7, 16'h0006);
    exp_crc = crc_feed(exp_crc, 16'h003C, 8, 4'h7, 16'h0006);
    // Stops exactly at full: never writes data while the full flag is set
    for (int i = 0; i < 13; i++) begin
      wr(2'h2, 2'h2, {i[7:0], 8'hFF});
      exp_crc = crc_feed(exp_crc, {8'h00, i[7:0]}, 8, 4'h7, 16'h0006);
    end
    check(2'h0, 16'h1087);
    sys_idle = 1'b1;
    wr(2'h0, 2'h3, 16'h2017);
    repeat (20) @(posedge core_clk);
    check(2'h0, 16'h3097);
    sys_idle = 1'b0;
    wr(2'h0, 2'h3, 16'h0007);
    repeat (8) @(posedge core_clk);
    check(2'h0, 16'h0F07);
    // Idle stop while running: shifter parks mid byte, count must hold at 15
    sys_idle = 1'b1;
    wr(2'h0, 2'h3, 16'h2007);
    repeat (20) @(posedge core_clk);
    check(2'h0, 16'h2F07);
    sys_idle = 1'b0;
    wr(2'h0, 2'h3, 16'h0007);
    wait_empty();
    check(2'h3, exp_crc);
    samples_checked++;
    if (irq_count != 2) begin
      num_errors++;
      $display("ERROR at %0t: %0d interrupts, expected 2", $time, irq_count);
    end
    conclude();
  end
endmodule : test_pcg_top
